// [hw/qsb_defines.svh]
`ifndef QSB_DEFINES_SVH
`define QSB_DEFINES_SVH

// clock rate of the module-side and host-side logic
`define QSB_CLK_MHZ          200

// management map of the module (byte addresses)
`define QSB_ADDR_STATUS      8'h02
`define QSB_ADDR_FLAGS       8'h03
`define QSB_ADDR_MASK        8'h04
`define QSB_ADDR_CTRL        8'h05

// field positions
`define QSB_STATUS_DNR_BIT   0
`define QSB_FLAG_RX_LOS_BIT  0
`define QSB_FLAG_TX_FLT_BIT  1
`define QSB_FLAG_OTHER_BIT   2
`define QSB_FLAG_RST_DONE_BIT 3
`define QSB_CTRL_PDOWN_BIT   0

// reset values
`define QSB_FLAGS_RST        4'h0
`define QSB_MASK_RST         4'h0
`define QSB_CTRL_RST         1'b0

// timing: times in their own unit, counts derived from the clock rate
`define QSB_T_RESET_MIN_US   2
`define QSB_RESET_MIN_CYC    (`QSB_T_RESET_MIN_US * `QSB_CLK_MHZ)
`define QSB_T_INIT_MS        2000
`define QSB_INIT_CYC         (`QSB_T_INIT_MS * 1000 * `QSB_CLK_MHZ)

// host register offsets
`define QSB_HREG_CTRL        8'h00
`define QSB_HREG_STATUS      8'h04
`define QSB_HREG_XFER        8'h08
`define QSB_HREG_RDATA       8'h0C

// host control fields and reset value
`define QSB_HCTRL_SEL_BIT    0
`define QSB_HCTRL_RST_BIT    1
`define QSB_HCTRL_LP_BIT     2
`define QSB_HCTRL_RST        3'h0

// host xfer fields
`define QSB_XFER_WE_BIT      16

// cycles the host waits for a management answer
`define QSB_ACK_WAIT         4'h8

`endif

// [hw/qsb_pkg.sv]
package qsb_pkg;

  typedef enum logic [1:0]
  {
    QSB_ST_INIT  = 2'b00,
    QSB_ST_READY = 2'b01,
    QSB_ST_HELD  = 2'b11
  } qsb_dev_state_t;

  typedef enum logic [1:0]
  {
    QSB_HS_IDLE = 2'b00,
    QSB_HS_WAIT = 2'b01
  } qsb_host_state_t;

  function automatic logic qsb_int_pending(input logic [3:0] flags, input logic [3:0] mask);
    qsb_int_pending = |(flags & ~mask);
  endfunction

endpackage

// [hw/qsb_sideband_if.sv]
interface qsb_sideband_if;

  // host-driven pins; select has its own enable so an undriven pin floats high
  logic       module_select_n_o;
  logic       module_select_n_oe;
  logic       module_reset_n;
  logic       low_power_request;

  // module-driven open-drain pins
  logic       interrupt_out_n_o;
  logic       interrupt_out_n_oe;
  logic       module_present_n_o;
  logic       module_present_n_oe;

  // resolved wire levels, pull-ups modelled here
  logic       module_select_n;
  logic       interrupt_out_n;
  logic       module_present_n;

  // abstract management transfer, one request per completed 2-wire transaction
  logic       mgmt_req;
  logic       mgmt_we;
  logic [7:0] mgmt_addr;
  logic [7:0] mgmt_wdata;
  logic       mgmt_ack;
  logic [7:0] mgmt_rdata;

  assign module_select_n  = module_select_n_oe ? module_select_n_o : 1'b1;
  assign interrupt_out_n  = interrupt_out_n_oe ? interrupt_out_n_o : 1'b1;
  assign module_present_n = module_present_n_oe ? module_present_n_o : 1'b1;

  modport module_mp
  (
    input  module_select_n,
    input  module_reset_n,
    input  low_power_request,
    output interrupt_out_n_o,
    output interrupt_out_n_oe,
    output module_present_n_o,
    output module_present_n_oe,
    input  mgmt_req,
    input  mgmt_we,
    input  mgmt_addr,
    input  mgmt_wdata,
    output mgmt_ack,
    output mgmt_rdata
  );

  modport host_mp
  (
    output module_select_n_o,
    output module_select_n_oe,
    output module_reset_n,
    output low_power_request,
    input  interrupt_out_n,
    input  module_present_n,
    output mgmt_req,
    output mgmt_we,
    output mgmt_addr,
    output mgmt_wdata,
    input  mgmt_ack,
    input  mgmt_rdata
  );

endinterface

// [hw/qsb_timer.sv]
module qsb_timer
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        start_i,
  input  wire logic [31:0] load_i,
  output logic             done_o
);

  logic [31:0] count_reg;
  logic [31:0] count_next;

  // a new start always reloads, so a repeated trigger restarts the interval
  assign count_next = start_i ? load_i : ((count_reg != 32'h0) ? count_reg - 32'h1 : 32'h0);

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      count_reg <= 32'h0;
      done_o    <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      done_o    <= !start_i && (count_reg == 32'h1);
    end
  end

endmodule

// [hw/qsb_module_end.sv]
// Contract
// - selected module answers management commands
// - deselected module stays silent on management bus
// - undriven select floats to deselected high
// - reset low beyond 2us restores defaults
// - init starts at reset release, 2000ms
// - completion: interrupt with data-not-ready cleared
// - host ignores status until completion interrupt
// - power-up raises completion interrupt unaided
// - data-not-ready clears, interrupt within 2000ms
// - management answers within 2000ms of power-on
// - low-power request lowers power within 100us
// - presence grounded by module, pulled up host
// - interrupt is active-low open-collector
// - host reads flags after interrupt low
// - interrupt low within 200ms of cause
// - flags clear on read, release 500us
// - receive loss flag and interrupt, 100ms
// - transmit fault flag and interrupt, 200ms
// - other flags set and interrupt, 200ms
// - mask blocks or restores interrupt, 100ms
// - select gates answers within 100us
// - power-down override lowers, restores power
//
// Chosen here: strobed register access and the address map.
`include "qsb_defines.svh"

module qsb_module_end
  import qsb_pkg::*;
#(
  parameter int unsigned INIT_CYC = `QSB_INIT_CYC
)
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  qsb_sideband_if.module_mp sb,
  input  wire logic       rx_los_i,
  input  wire logic       tx_fault_i,
  input  wire logic       other_fault_i,
  output logic            power_low_o,
  output logic            ready_o
);

  qsb_dev_state_t state_reg;
  qsb_dev_state_t state_next;

  logic       pwron_reg;
  logic       rst_prev_reg;
  logic       sel_reg;
  logic       dnr_reg;
  logic [3:0] flags_reg;
  logic [3:0] mask_reg;
  logic       pdown_reg;
  logic       int_oe_reg;
  logic       ack_reg;
  logic [7:0] rdata_reg;
  logic       power_low_reg;
  logic       ready_reg;

  wire        rst_fall;
  wire        rst_rise;
  wire        qual_done;
  wire        init_start;
  wire        init_done;
  wire        soft_reset;
  wire        access;
  wire        rd_flags;
  wire        wr_mask;
  wire        wr_ctrl;
  wire [3:0]  flag_set;
  wire [3:0]  flag_clr;
  wire [3:0]  flags_next;
  wire [7:0]  rd_mux;

  // pin edges; pins are taken as synchronous to clk_i
  assign rst_fall = rst_prev_reg && !sb.module_reset_n;
  assign rst_rise = !rst_prev_reg && sb.module_reset_n;

  // qualifies the reset pulse width; a new falling edge restarts the count
  qsb_timer u_rst_qual
  (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .start_i (rst_fall),
    .load_i  (32'(`QSB_RESET_MIN_CYC)),
    .done_o  (qual_done)
  );

  // a glitch shorter than the minimum leaves the timer running; ignore a late done
  assign soft_reset = qual_done && !sb.module_reset_n;

  // initialization after power-on or after a qualified reset is released
  assign init_start = pwron_reg || (state_reg == QSB_ST_HELD && rst_rise);

  qsb_timer u_init
  (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .start_i (init_start),
    .load_i  (32'(INIT_CYC)),
    .done_o  (init_done)
  );

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      QSB_ST_INIT:
      begin
        if (soft_reset)
          state_next = QSB_ST_HELD;
        else if (init_done)
          state_next = QSB_ST_READY;
      end
      QSB_ST_READY:
      begin
        if (soft_reset)
          state_next = QSB_ST_HELD;
      end
      QSB_ST_HELD:
      begin
        if (rst_rise)
          state_next = QSB_ST_INIT;
      end
      default:
      begin
        state_next = QSB_ST_INIT;
      end
    endcase
  end

  // management access decode: only while selected and initialized
  assign access   = sb.mgmt_req && sel_reg && (state_reg == QSB_ST_READY);
  assign rd_flags = access && !sb.mgmt_we && (sb.mgmt_addr == `QSB_ADDR_FLAGS);
  assign wr_mask  = access && sb.mgmt_we && (sb.mgmt_addr == `QSB_ADDR_MASK);
  assign wr_ctrl  = access && sb.mgmt_we && (sb.mgmt_addr == `QSB_ADDR_CTRL);

  // conditions are level sensitive, so a still-present fault sets again after a read
  assign flag_set[`QSB_FLAG_RX_LOS_BIT]   = rx_los_i && (state_reg == QSB_ST_READY);
  assign flag_set[`QSB_FLAG_TX_FLT_BIT]   = tx_fault_i && (state_reg == QSB_ST_READY);
  assign flag_set[`QSB_FLAG_OTHER_BIT]    = other_fault_i && (state_reg == QSB_ST_READY);
  assign flag_set[`QSB_FLAG_RST_DONE_BIT] = init_done && (state_reg == QSB_ST_INIT);

  // clear on read; a set in the same cycle wins
  assign flag_clr   = rd_flags ? 4'hF : 4'h0;
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;

  assign rd_mux = (sb.mgmt_addr == `QSB_ADDR_STATUS) ? {7'h00, dnr_reg} :
                  (sb.mgmt_addr == `QSB_ADDR_FLAGS)  ? {4'h0, flags_reg} :
                  (sb.mgmt_addr == `QSB_ADDR_MASK)   ? {4'h0, mask_reg} :
                  (sb.mgmt_addr == `QSB_ADDR_CTRL)   ? {7'h00, pdown_reg} :
                  8'h00;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg    <= QSB_ST_INIT;
      pwron_reg    <= 1'b1;
      rst_prev_reg <= 1'b1;
      sel_reg      <= 1'b0;
    end
    else
    begin
      state_reg    <= state_next;
      pwron_reg    <= 1'b0;
      rst_prev_reg <= sb.module_reset_n;
      sel_reg      <= !sb.module_select_n;
    end
  end

  // user settings return to defaults on power-on and on a qualified reset
  always_ff @(posedge clk_i)
  begin
    if (srst_i || soft_reset)
    begin
      flags_reg <= `QSB_FLAGS_RST;
      mask_reg  <= `QSB_MASK_RST;
      pdown_reg <= `QSB_CTRL_RST;
      dnr_reg   <= 1'b1;
    end
    else
    begin
      flags_reg <= flags_next;
      if (wr_mask)
        mask_reg <= sb.mgmt_wdata[3:0];
      if (wr_ctrl)
        pdown_reg <= sb.mgmt_wdata[`QSB_CTRL_PDOWN_BIT];
      if (flag_set[`QSB_FLAG_RST_DONE_BIT])
        dnr_reg <= 1'b0;
    end
  end

  // outputs other than the constant pin levels, each from a flop
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      int_oe_reg    <= 1'b0;
      ack_reg       <= 1'b0;
      rdata_reg     <= 8'h00;
      power_low_reg <= 1'b0;
      ready_reg     <= 1'b0;
    end
    else
    begin
      // mask and flags act two cycles after the write or read, far inside the limits
      int_oe_reg    <= qsb_int_pending(flags_reg, mask_reg);
      ack_reg       <= access;
      rdata_reg     <= (access && !sb.mgmt_we) ? rd_mux : 8'h00;
      power_low_reg <= sb.low_power_request || pdown_reg;
      ready_reg     <= (state_reg == QSB_ST_READY) && !dnr_reg;
    end
  end

  assign sb.interrupt_out_n_o   = 1'b0;
  assign sb.interrupt_out_n_oe  = int_oe_reg;
  // presence is grounded, driven from reset onward
  assign sb.module_present_n_o  = 1'b0;
  assign sb.module_present_n_oe = 1'b1;
  assign sb.mgmt_ack            = ack_reg;
  assign sb.mgmt_rdata          = rdata_reg;
  assign power_low_o            = power_low_reg;
  assign ready_o                = ready_reg;

endmodule

// [hw/qsb_host_end.sv]
`include "qsb_defines.svh"

module qsb_host_end
  import qsb_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  qsb_sideband_if.host_mp  sb,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        we_i,
  input  wire logic        re_i,
  output logic [31:0]      rdata_o
);

  qsb_host_state_t state_reg;

  logic [2:0]  ctrl_reg;
  logic        sel_n_reg;
  logic        reset_n_reg;
  logic        lp_reg;
  logic        req_reg;
  logic        xwe_reg;
  logic [7:0]  xaddr_reg;
  logic [7:0]  xwdata_reg;
  logic [3:0]  wait_reg;
  logic [7:0]  xrdata_reg;
  logic        ack_ok_reg;
  logic        pend_reg;
  logic [31:0] rdata_reg;

  wire         wr_ctrl;
  wire         wr_xfer;
  wire         busy;
  wire         release_rst;
  wire [31:0]  status;
  wire [31:0]  rd_mux;

  assign busy        = (state_reg == QSB_HS_WAIT);
  assign wr_ctrl     = we_i && (addr_i == `QSB_HREG_CTRL);
  // a transfer written while one is outstanding is dropped
  assign wr_xfer     = we_i && (addr_i == `QSB_HREG_XFER) && !busy;
  assign release_rst = wr_ctrl && ctrl_reg[`QSB_HCTRL_RST_BIT] && !wdata_i[`QSB_HCTRL_RST_BIT];

  assign status = {27'h0, pend_reg, ack_ok_reg, busy, !sb.interrupt_out_n, !sb.module_present_n};
  assign rd_mux = (addr_i == `QSB_HREG_CTRL)   ? {29'h0, ctrl_reg} :
                  (addr_i == `QSB_HREG_STATUS) ? status :
                  (addr_i == `QSB_HREG_XFER)   ? {15'h0, xwe_reg, xwdata_reg, xaddr_reg} :
                  (addr_i == `QSB_HREG_RDATA)  ? {24'h0, xrdata_reg} :
                  32'h0;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg    <= `QSB_HCTRL_RST;
      sel_n_reg   <= 1'b1;
      reset_n_reg <= 1'b1;
      lp_reg      <= 1'b0;
      rdata_reg   <= 32'h0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= wdata_i[2:0];
      sel_n_reg   <= !ctrl_reg[`QSB_HCTRL_SEL_BIT];
      reset_n_reg <= !ctrl_reg[`QSB_HCTRL_RST_BIT];
      lp_reg      <= ctrl_reg[`QSB_HCTRL_LP_BIT];
      rdata_reg   <= re_i ? rd_mux : 32'h0;
    end
  end

  // status is meaningless from reset release until the completion interrupt
  always_ff @(posedge clk_i)
  begin
    if (srst_i)
      pend_reg <= 1'b1;
    else if (release_rst)
      pend_reg <= 1'b1;
    else if (!sb.interrupt_out_n)
      pend_reg <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg  <= QSB_HS_IDLE;
      req_reg    <= 1'b0;
      xwe_reg    <= 1'b0;
      xaddr_reg  <= 8'h00;
      xwdata_reg <= 8'h00;
      wait_reg   <= 4'h0;
      xrdata_reg <= 8'h00;
      ack_ok_reg <= 1'b0;
    end
    else
    begin
      req_reg <= wr_xfer;
      case (state_reg)
        QSB_HS_IDLE:
        begin
          if (wr_xfer)
          begin
            xaddr_reg  <= wdata_i[7:0];
            xwdata_reg <= wdata_i[15:8];
            xwe_reg    <= wdata_i[`QSB_XFER_WE_BIT];
            wait_reg   <= `QSB_ACK_WAIT;
            ack_ok_reg <= 1'b0;
            state_reg  <= QSB_HS_WAIT;
          end
        end
        QSB_HS_WAIT:
        begin
          if (sb.mgmt_ack)
          begin
            xrdata_reg <= sb.mgmt_rdata;
            ack_ok_reg <= 1'b1;
            state_reg  <= QSB_HS_IDLE;
          end
          else if (wait_reg == 4'h0)
            state_reg <= QSB_HS_IDLE;
          else
            wait_reg <= wait_reg - 4'h1;
        end
        default:
        begin
          state_reg <= QSB_HS_IDLE;
        end
      endcase
    end
  end

  assign sb.module_select_n_o  = sel_n_reg;
  assign sb.module_select_n_oe = 1'b1;
  assign sb.module_reset_n     = reset_n_reg;
  assign sb.low_power_request  = lp_reg;
  assign sb.mgmt_req           = req_reg;
  assign sb.mgmt_we            = xwe_reg;
  assign sb.mgmt_addr          = xaddr_reg;
  assign sb.mgmt_wdata         = xwdata_reg;
  assign rdata_o               = rdata_reg;

endmodule

// [dv/qsb_sideband_asserts.sv]
module qsb_sideband_asserts
#(
  parameter int INIT_CYC = 50
)
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       module_select_n,
  input  wire logic       module_reset_n,
  input  wire logic       interrupt_out_n,
  input  wire logic       interrupt_out_n_o,
  input  wire logic       module_present_n,
  input  wire logic       mgmt_req,
  input  wire logic       mgmt_ack,
  input  wire logic [7:0] mgmt_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // a few cycles of slack for the flag and pin flops behind the init timer
  localparam int INIT_HI = INIT_CYC + 8;

  logic [9:0] since_reg;
  logic [9:0] low_reg;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  // both counters saturate so long idle stretches never wrap back into range
  always_ff @(posedge clk_i)
  begin
    since_reg <= srst_i ? 10'h000 : since_reg + {9'h000, since_reg != 10'h3FF};
    low_reg   <= module_reset_n ? 10'h000 : low_reg + {9'h000, low_reg != 10'h3FF};
  end

  AST_ACK_CAUSE: assert property (mgmt_ack |-> $past(mgmt_req))
    else $error("management ack without a request");
  AST_DESEL_SILENT: assert property (module_select_n [*2] |=> !mgmt_ack)
    else $error("deselected module answered");
  AST_RDATA_IDLE: assert property (!mgmt_ack |-> mgmt_rdata == 8'h00)
    else $error("read data driven outside an answer");
  AST_PRESENT: assert property (module_present_n == 1'b0)
    else $error("presence line not held low");
  AST_INT_OPEN_DRAIN: assert property (interrupt_out_n_o == 1'b0)
    else $error("interrupt pin driven high");
  AST_INIT_QUIET: assert property (since_reg < INIT_CYC |-> interrupt_out_n && !mgmt_ack)
    else $error("activity before initialisation finished");
  AST_POWERUP_INT: assert property ($fell(srst_i) |-> ##[1:INIT_HI] !interrupt_out_n)
    else $error("no completion interrupt after power-up");
  AST_HELD_QUIET: assert property (low_reg > 10'h195 |-> interrupt_out_n && !mgmt_ack)
    else $error("module active while held in reset");

  cover property (mgmt_ack);
  cover property (!interrupt_out_n);
  cover property (low_reg == 10'h19A);
endmodule

// [dv/tb_module_sideband_control.sv]
`include "qsb_defines.svh"

module tb_module_sideband_control;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int INIT_CYC = 50;

  typedef struct {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } qsb_row_t;

  logic        clk_i;
  logic        srst_i;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i;
  logic        we_i;
  logic        re_i;
  logic [31:0] rdata_o;
  logic [2:0]  fault;
  logic        power_low_o;
  logic        ready_o;
  logic [31:0] rd_val;
  logic        acked;
  int          errors;
  int          cmp_count;
  qsb_row_t    rows [7];

  qsb_sideband_if sb_if ();

  qsb_module_end #(.INIT_CYC(INIT_CYC)) qsb_module_end_i
  (
    .clk_i         (clk_i),
    .srst_i        (srst_i),
    .sb            (sb_if.module_mp),
    .rx_los_i      (fault[0]),
    .tx_fault_i    (fault[1]),
    .other_fault_i (fault[2]),
    .power_low_o   (power_low_o),
    .ready_o       (ready_o)
  );

  qsb_host_end qsb_host_end_i
  (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .sb      (sb_if.host_mp),
    .addr_i  (addr_i),
    .wdata_i (wdata_i),
    .we_i    (we_i),
    .re_i    (re_i),
    .rdata_o (rdata_o)
  );

  qsb_sideband_asserts #(.INIT_CYC(INIT_CYC)) qsb_sideband_asserts_i
  (
    .clk_i             (clk_i),
    .srst_i            (srst_i),
    .module_select_n   (sb_if.module_select_n),
    .module_reset_n    (sb_if.module_reset_n),
    .interrupt_out_n   (sb_if.interrupt_out_n),
    .interrupt_out_n_o (sb_if.interrupt_out_n_o),
    .module_present_n  (sb_if.module_present_n),
    .mgmt_req          (sb_if.mgmt_req),
    .mgmt_ack          (sb_if.mgmt_ack),
    .mgmt_rdata        (sb_if.mgmt_rdata)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 rd_val = rdata_o;
  endtask

  // one management transfer; polls busy so a silent module ends in a timeout
  task automatic mx(input logic we, input logic [7:0] a, input logic [7:0] d);
    int n;
    wr(`QSB_HREG_XFER, {15'h0000, we, d, a});
    n = 0;
    rd_val = 32'h4;
    while (rd_val[2] !== 1'b0 && n < 16)
    begin
      rd(`QSB_HREG_STATUS);
      n++;
    end
    chk("xfer_busy", {31'h0, rd_val[2]}, 32'h0);
    if (rd_val[2] !== 1'b0)
      conclude();
    acked = rd_val[3];
    rd(`QSB_HREG_RDATA);
  endtask

  task automatic mchk(input logic [7:0] a, input logic [7:0] e);
    mx(1'b0, a, 8'h00);
    chk("mgmt_ack", {31'h0, acked}, 32'h1);
    chk("mgmt_rdata", rd_val & 32'hFF, {24'h0, e});
  endtask

  task automatic wait_int(input logic lvl, input int lim);
    int n;
    n = 0;
    while (sb_if.interrupt_out_n !== lvl && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk("int_level", {31'h0, sb_if.interrupt_out_n}, {31'h0, lvl});
    if (sb_if.interrupt_out_n !== lvl)
      conclude();
  endtask

  task automatic pulse(input logic [2:0] f);
    @(posedge clk_i);
    fault <= f;
    @(posedge clk_i);
    fault <= 3'h0;
  endtask

  task automatic power_is(input logic e);
    repeat (4) @(negedge clk_i);
    chk("power_low", {31'h0, power_low_o}, {31'h0, e});
  endtask

  initial
  begin
    srst_i = 1'b1;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    we_i = 1'b0;
    re_i = 1'b0;
    fault = 3'h0;
    errors = 0;
    cmp_count = 0;
    rows = '{
      '{1'b0, `QSB_ADDR_STATUS, 8'h00, 8'h00},
      '{1'b0, `QSB_ADDR_FLAGS, 8'h00, 8'h08},
      '{1'b0, `QSB_ADDR_FLAGS, 8'h00, 8'h00},
      '{1'b1, `QSB_ADDR_MASK, 8'h0F, 8'h00},
      '{1'b0, `QSB_ADDR_MASK, 8'h00, 8'h0F},
      '{1'b1, `QSB_ADDR_MASK, 8'h00, 8'h00},
      '{1'b0, 8'h07, 8'h00, 8'h00}
    };
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`QSB_HREG_STATUS);
    chk("host_status", rd_val, 32'h0000_0011);
    chk("select_idle", {31'h0, sb_if.module_select_n}, 32'h1);
    chk("present", {31'h0, sb_if.module_present_n}, 32'h0);
    wait_int(1'b0, INIT_CYC + 20);
    chk("ready", {31'h0, ready_o}, 32'h1);
    rd(`QSB_HREG_STATUS);
    chk("status_int", rd_val & 32'h13, 32'h03);
    wr(`QSB_HREG_CTRL, 32'h1);
    foreach (rows[k])
    begin
      mx(rows[k].we, rows[k].addr, rows[k].wdata);
      chk("row_ack", {31'h0, acked}, 32'h1);
      if (!rows[k].we)
        chk("row_rdata", rd_val & 32'hFF, {24'h0, rows[k].exp});
    end
    wait_int(1'b1, 10);
    rd(8'h10);
    chk("host_unmapped", rd_val, 32'h0);
    wr(`QSB_HREG_CTRL, 32'h0);
    mx(1'b0, `QSB_ADDR_FLAGS, 8'h00);
    chk("desel_ack", {31'h0, acked}, 32'h0);
    wr(`QSB_HREG_CTRL, 32'h1);
    for (int i = 0; i < 3; i++)
    begin
      pulse(3'h1 << i);
      wait_int(1'b0, 10);
      mchk(`QSB_ADDR_FLAGS, 8'h01 << i);
      wait_int(1'b1, 10);
    end
    mx(1'b1, `QSB_ADDR_MASK, 8'h01);
    pulse(3'h1);
    repeat (10) @(negedge clk_i);
    chk("int_masked", {31'h0, sb_if.interrupt_out_n}, 32'h1);
    mx(1'b1, `QSB_ADDR_MASK, 8'h00);
    wait_int(1'b0, 10);
    mchk(`QSB_ADDR_FLAGS, 8'h01);
    wait_int(1'b1, 10);
    wr(`QSB_HREG_CTRL, 32'h5);
    power_is(1'b1);
    wr(`QSB_HREG_CTRL, 32'h1);
    power_is(1'b0);
    mx(1'b1, `QSB_ADDR_CTRL, 8'h01);
    power_is(1'b1);
    mchk(`QSB_ADDR_CTRL, 8'h01);
    mx(1'b1, `QSB_ADDR_CTRL, 8'h00);
    power_is(1'b0);
    // a pulse well under the qualifier must leave the settings alone
    mx(1'b1, `QSB_ADDR_MASK, 8'h02);
    wr(`QSB_HREG_CTRL, 32'h3);
    repeat (100) @(negedge clk_i);
    wr(`QSB_HREG_CTRL, 32'h1);
    mchk(`QSB_ADDR_MASK, 8'h02);
    wr(`QSB_HREG_CTRL, 32'h3);
    repeat (430) @(negedge clk_i);
    chk("held_ready", {31'h0, ready_o}, 32'h0);
    wr(`QSB_HREG_CTRL, 32'h1);
    rd(`QSB_HREG_STATUS);
    chk("pending", rd_val & 32'h12, 32'h10);
    wait_int(1'b0, INIT_CYC + 20);
    mchk(`QSB_ADDR_STATUS, 8'h00);
    mchk(`QSB_ADDR_MASK, 8'h00);
    mchk(`QSB_ADDR_FLAGS, 8'h08);
    conclude();
  end
endmodule
